// ==== design/nbr_ram_port.sv ====
`timescale 1ns/10ps
module nbr_ram_port
  import nbr_pkg::*;
#(
  // Metal option: upper chip-number bit this part answers to
  parameter logic CHIP_OPTION = 1'b0
) (
  // System
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Processor timing
  input  wire logic       phaseTwo,
  input  wire logic       syncIn,
  input  wire logic       ramBankLine,
  // Strap
  input  wire logic       chipOptionPin,
  // Nibble bus, split into three signals
  input  wire logic [3:0] busIn,
  output logic      [3:0] busOut,
  output logic            busOe,
  // Output port
  output logic      [3:0] outputPortLines
);

  logic       stepPulse;
  logic [2:0] subIdx;
  logic [3:0] busCap;
  logic       bankCap;

  nbr_subcycle_timer u_timer (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .phaseTwo    (phaseTwo),
    .syncIn      (syncIn),
    .ramBankLine (ramBankLine),
    .busIn       (busIn),
    .stepPulse   (stepPulse),
    .subIdx      (subIdx),
    .busCap      (busCap),
    .bankCap     (bankCap)
  );

  // Control state
  logic       selected;
  logic       selectPending;
  logic [1:0] regSel;
  logic [3:0] charSel;
  logic [3:0] opField;
  logic       opValid;

  // Storage: main characters indexed {register, character}
  logic [3:0] mainMem   [MAIN_DEPTH];
  logic [3:0] statusMem [STATUS_DEPTH];

  logic       next_selected;
  logic       next_selectPending;
  logic [1:0] next_regSel;
  logic [3:0] next_charSel;
  logic [3:0] next_opField;
  logic       next_opValid;
  logic [3:0] next_busOut;
  logic       next_busOe;
  logic [3:0] next_outputPortLines;
  logic [3:0] next_mainMem   [MAIN_DEPTH];
  logic [3:0] next_statusMem [STATUS_DEPTH];

  // Decoded access
  logic [5:0] mainAddr;
  logic [3:0] statusAddr;
  logic       isRead;
  logic       isMainRead;
  logic       isStatusRead;
  logic       isMainWrite;
  logic       isStatusWrite;
  logic       isPortWrite;
  logic       active;
  logic [1:0] myChip;

  assign myChip     = {CHIP_OPTION, chipOptionPin};
  assign mainAddr   = {regSel, charSel};
  assign statusAddr = {regSel, opField[1:0]};
  assign active     = opValid & selected;
  assign isRead     = opField[DIR_BIT];

  // Port reads and writes of other device families are ignored here
  always_comb begin
    isMainRead    = 1'b0;
    isStatusRead  = 1'b0;
    isMainWrite   = 1'b0;
    isStatusWrite = 1'b0;
    isPortWrite   = 1'b0;
    if (isRead) begin
      if (opField[STATUS_GRP_BIT]) begin
        isStatusRead = 1'b1;
      end else begin
        case (opField)
          OP_SUB_MEM:   isMainRead = 1'b1;
          OP_READ_MAIN: isMainRead = 1'b1;
          OP_ADD_MEM:   isMainRead = 1'b1;
          OP_READ_ROMP: isMainRead = 1'b0;
          default:      isMainRead = 1'b0;
        endcase
      end
    end else begin
      if (opField[STATUS_GRP_BIT]) begin
        isStatusWrite = 1'b1;
      end else begin
        case (opField)
          OP_WRITE_MAIN: isMainWrite = 1'b1;
          OP_WRITE_PORT: isPortWrite = 1'b1;
          OP_WRITE_ROMP: isPortWrite = 1'b0;
          OP_WRITE_PROG: isPortWrite = 1'b0;
          default:       isPortWrite = 1'b0;
        endcase
      end
    end
  end

  always_comb begin
    next_selected        = selected;
    next_selectPending   = selectPending;
    next_regSel          = regSel;
    next_charSel         = charSel;
    next_opField         = opField;
    next_opValid         = opValid;
    next_busOut          = busOut;
    next_busOe           = busOe;
    next_outputPortLines = outputPortLines;
    next_mainMem         = mainMem;
    next_statusMem       = statusMem;

    if (stepPulse) begin
      case (subIdx)
        SUB_MEM_TWO: begin
          // Bank line here means an I/O or memory instruction follows
          next_opValid = bankCap;
          if (bankCap) begin
            next_opField = busCap;
          end
        end
        SUB_EXEC_ZERO: begin
          // Drive read data from the start of exec one, from a flop
          if (active && (isMainRead || isStatusRead)) begin
            next_busOe = 1'b1;
            if (isMainRead) begin
              next_busOut = mainMem[mainAddr];
            end else begin
              next_busOut = statusMem[statusAddr];
            end
          end
        end
        SUB_EXEC_ONE: begin
          next_busOe = 1'b0;
          if (bankCap && !opValid) begin
            // Bank line without pending operation: register select
            next_selected      = (busCap[3:2] == myChip);
            next_regSel        = busCap[1:0];
            next_selectPending = 1'b1;
          end else begin
            next_selectPending = 1'b0;
          end
          if (active) begin
            if (isPortWrite) begin
              next_outputPortLines = busCap;
            end
            if (isMainWrite) begin
              next_mainMem[mainAddr] = busCap;
            end
            if (isStatusWrite) begin
              next_statusMem[statusAddr] = busCap;
            end
          end
          next_opValid = 1'b0;
        end
        SUB_EXEC_TWO: begin
          if (selectPending) begin
            next_charSel = busCap;
          end
          next_selectPending = 1'b0;
        end
        default: begin
          next_busOe = busOe;
        end
      endcase
    end
  end

  // Whole array cleared in one cycle; the real part needs many cycles
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      selected        <= 1'b0;
      selectPending   <= 1'b0;
      regSel          <= INDEX_RST;
      charSel         <= NIBBLE_RST;
      opField         <= NIBBLE_RST;
      opValid         <= 1'b0;
      busOut          <= NIBBLE_RST;
      busOe           <= 1'b0;
      outputPortLines <= NIBBLE_RST;
      for (int i = 0; i < MAIN_DEPTH; i++) begin
        mainMem[i] <= NIBBLE_RST;
      end
      for (int j = 0; j < STATUS_DEPTH; j++) begin
        statusMem[j] <= NIBBLE_RST;
      end
    end else begin
      selected        <= next_selected;
      selectPending   <= next_selectPending;
      regSel          <= next_regSel;
      charSel         <= next_charSel;
      opField         <= next_opField;
      opValid         <= next_opValid;
      busOut          <= next_busOut;
      busOe           <= next_busOe;
      outputPortLines <= next_outputPortLines;
      mainMem         <= next_mainMem;
      statusMem       <= next_statusMem;
    end
  end

endmodule // nbr_ram_port

// ==== design/nbr_pkg.sv ====
package nbr_pkg;

  // Widths and array sizes
  localparam int NIBBLE_W      = 4;
  localparam int REG_COUNT     = 4;
  localparam int MAIN_CHARS    = 16;
  localparam int STATUS_CHARS  = 4;
  localparam int MAIN_DEPTH    = REG_COUNT * MAIN_CHARS;
  localparam int STATUS_DEPTH  = REG_COUNT * STATUS_CHARS;

  // Subcycle numbering inside one instruction cycle of eight
  localparam logic [2:0] SUB_FIRST      = 3'h0;
  localparam logic [2:0] SUB_MEM_TWO    = 3'h4;
  localparam logic [2:0] SUB_EXEC_ZERO  = 3'h5;
  localparam logic [2:0] SUB_EXEC_ONE   = 3'h6;
  localparam logic [2:0] SUB_EXEC_TWO   = 3'h7;

  // Operation field codes seen on the bus in the memory subcycle
  localparam logic [3:0] OP_WRITE_MAIN   = 4'h0;
  localparam logic [3:0] OP_WRITE_PORT   = 4'h1;
  localparam logic [3:0] OP_WRITE_ROMP   = 4'h2;
  localparam logic [3:0] OP_WRITE_PROG   = 4'h3;
  localparam logic [3:0] OP_SUB_MEM      = 4'h8;
  localparam logic [3:0] OP_READ_MAIN    = 4'h9;
  localparam logic [3:0] OP_READ_ROMP    = 4'hA;
  localparam logic [3:0] OP_ADD_MEM      = 4'hB;

  // Field positions
  localparam int DIR_BIT        = 3;
  localparam int STATUS_GRP_BIT = 2;

  // Reset values
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  localparam logic [1:0] INDEX_RST  = 2'h0;

  // Clear-on-reset needs this many instruction cycles on the real pin
  localparam int RESET_INSTR_CYCLES = 32;

endpackage

// ==== design/nbr_subcycle_timer.sv ====
`timescale 1ns/10ps
module nbr_subcycle_timer
  import nbr_pkg::*;
(
  // System
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Processor timing and bus
  input  wire logic       phaseTwo,
  input  wire logic       syncIn,
  input  wire logic       ramBankLine,
  input  wire logic [3:0] busIn,
  // Per-subcycle results
  output logic            stepPulse,
  output logic [2:0]      subIdx,
  output logic [3:0]      busCap,
  output logic            bankCap
);

  logic       phasePrev;
  logic       syncCap;
  logic       next_phasePrev;
  logic       next_syncCap;
  logic       next_bankCap;
  logic [3:0] next_busCap;
  logic [2:0] next_subIdx;

  // Subcycle ends when phase two falls; values held from its high part
  assign stepPulse = phasePrev & ~phaseTwo;

  always_comb begin
    next_phasePrev = phaseTwo;
    next_busCap    = busCap;
    next_bankCap   = bankCap;
    next_syncCap   = syncCap;
    next_subIdx    = subIdx;
    if (phaseTwo) begin
      next_busCap  = busIn;
      next_bankCap = ramBankLine;
      next_syncCap = syncIn;
    end
    // Framing pulse marks the last subcycle, so the next one is the first
    if (stepPulse) begin
      if (syncCap) begin
        next_subIdx = SUB_FIRST;
      end else begin
        next_subIdx = subIdx + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      phasePrev <= 1'b0;
      busCap    <= NIBBLE_RST;
      bankCap   <= 1'b0;
      syncCap   <= 1'b0;
      subIdx    <= SUB_FIRST;
    end else begin
      phasePrev <= next_phasePrev;
      busCap    <= next_busCap;
      bankCap   <= next_bankCap;
      syncCap   <= next_syncCap;
      subIdx    <= next_subIdx;
    end
  end

endmodule // nbr_subcycle_timer

// ==== test/nbr_ram_port_chk.sv ====
`timescale 1ns/10ps
module nbr_ram_port_chk
  import nbr_pkg::*;
(
  // System
  input wire logic       clk_sys,
  input wire logic       nrst,
  // Processor side
  input wire logic       phaseTwo,
  input wire logic       syncIn,
  input wire logic       ramBankLine,
  input wire logic       chipOptionPin,
  input wire logic [3:0] busIn,
  // Chip outputs
  input wire logic [3:0] busOut,
  input wire logic       busOe,
  input wire logic [3:0] outputPortLines
);
  // Own subcycle tracker, so a miscounting design cannot hide
  logic       p2d;
  logic       sy;
  logic       bk;
  logic       pend;
  logic [2:0] sub;
  logic [3:0] bs;
  logic [3:0] op;
  logic [3:0] d6;
  wire        fall = p2d && !phaseTwo;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      {p2d, sy, bk, pend, sub, bs, op, d6} <= '0;
    end else begin
      p2d <= phaseTwo;
      if (phaseTwo) {sy, bk, bs} <= {syncIn, ramBankLine, busIn};
      if (fall) begin
        sub <= sy ? 3'h0 : sub + 3'h1;
        if (sub == SUB_MEM_TWO) {pend, op} <= {bk, bs};
        if (sub == SUB_EXEC_ONE) d6 <= bs;
        if (sy) pend <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  rst_clear_a: assert property (
    $rose(nrst) |-> !busOe && outputPortLines == 4'h0)
    else $error("outputs not cleared by reset");
  oe_cause_a: assert property (
    $rose(busOe) |-> pend && op[DIR_BIT] && op != OP_READ_ROMP)
    else $error("bus driven without a memory read");
  oe_stop_a: assert property (
    fall && sub == SUB_EXEC_ONE |-> ##[1:2] !busOe)
    else $error("bus still driven after exec one");
  oe_hold_a: assert property ($rose(busOe) |-> busOe[*3])
    else $error("bus drive too short");
  out_stable_a: assert property (
    busOe && $past(busOe) |-> $stable(busOut))
    else $error("read data moved while driven");
  port_cause_a: assert property (
    $changed(outputPortLines) |-> pend && op == OP_WRITE_PORT)
    else $error("port changed without port write");
  port_value_a: assert property (
    $changed(outputPortLines) |-> outputPortLines == d6)
    else $error("port value differs from bus");
  idle_quiet_a: assert property (sub < SUB_MEM_TWO |-> !busOe)
    else $error("bus driven outside execute");

  cover property (pend && op == OP_READ_MAIN && busOe);
  cover property (pend && op[3:2] == 2'h3 && busOe);
  cover property ($changed(outputPortLines));
endmodule  // nbr_ram_port_chk

bind nbr_ram_port nbr_ram_port_chk chk (
  .clk_sys(clk_sys), .nrst(nrst), .phaseTwo(phaseTwo),
  .syncIn(syncIn), .ramBankLine(ramBankLine),
  .chipOptionPin(chipOptionPin), .busIn(busIn), .busOut(busOut),
  .busOe(busOe), .outputPortLines(outputPortLines));

// ==== test/nbr_cpu_model.sv ====
`timescale 1ns/10ps
module nbr_cpu_model (
  // System
  input  wire logic       clk_sys,
  // Timing and bus toward the chip
  output logic            phaseTwo,
  output logic            syncIn,
  output logic            ramBankLine,
  output logic      [3:0] cpuBus
);
  initial begin
    phaseTwo = 1'b0;
    syncIn = 1'b0;
    ramBankLine = 1'b0;
    cpuBus = 4'h0;
  end

  // One instruction cycle; bank at memory two (b4) and exec one (b6)
  task automatic cyc(input logic b4, input logic b6,
                     input logic [3:0] d4, input logic [3:0] d6,
                     input logic [3:0] d7);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk_sys);
      phaseTwo    <= 1'b1;
      syncIn      <= (s == 7);
      ramBankLine <= (s == 4) ? b4 : (s == 6) && b6;
      cpuBus      <= (s == 4) ? d4 : (s == 6) ? d6 : d7;
      repeat (2) @(posedge clk_sys);
      phaseTwo    <= 1'b0;
      ramBankLine <= 1'b0;
      // Released bus must not keep its last value
      cpuBus      <= ~cpuBus;
      @(posedge clk_sys);
    end
  endtask
endmodule  // nbr_cpu_model

// ==== test/tb_nbr_ram_port.sv ====
`timescale 1ns/10ps
module tb_nbr_ram_port;
  import nbr_pkg::*;
  logic        clk_sys;
  logic        nrst;
  logic        chipOptionPin;
  logic        phaseTwo;
  logic        syncIn;
  logic        ramBankLine;
  logic [3:0]  cpuBus;
  logic [3:0]  busIn;
  logic [3:0]  busOut;
  logic        busOe;
  logic [3:0]  outputPortLines;
  logic        prevOe;
  int          failures;
  int          checks_done;
  logic [3:0]  expQ[$];
  logic [3:0]  mem[MAIN_DEPTH];
  logic [3:0]  stat[STATUS_DEPTH];
  logic [3:0]  port;
  logic        sel;
  logic [1:0]  rg;
  logic [3:0]  ch;
  logic [31:0] rs = 32'h0000ED14;

  assign busIn = busOe ? busOut : cpuBus;

  nbr_ram_port dut (.clk_sys(clk_sys), .nrst(nrst), .phaseTwo(phaseTwo),
    .syncIn(syncIn), .ramBankLine(ramBankLine),
    .chipOptionPin(chipOptionPin), .busIn(busIn), .busOut(busOut),
    .busOe(busOe), .outputPortLines(outputPortLines));
  nbr_cpu_model cpu (.clk_sys(clk_sys), .phaseTwo(phaseTwo),
    .syncIn(syncIn), .ramBankLine(ramBankLine), .cpuBus(cpuBus));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [3:0] xr();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[3:0];
  endfunction

  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("BAD %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic clear_model();
    port = 4'h0;
    sel = 1'b0;
    foreach (mem[i]) mem[i] = 4'h0;
    foreach (stat[i]) stat[i] = 4'h0;
  endtask

  task automatic src(input logic [1:0] c, input logic [1:0] r,
                     input logic [3:0] k);
    sel = (c == {1'b0, chipOptionPin});
    rg = r;
    ch = k;
    cpu.cyc(1'b0, 1'b1, 4'h0, {c, r}, k);
  endtask

  task automatic io(input logic [3:0] op, input logic [3:0] d);
    if (sel) begin
      case (op)
        OP_WRITE_MAIN: mem[{rg, ch}] = d;
        OP_WRITE_PORT: port = d;
        4'h4, 4'h5, 4'h6, 4'h7: stat[{rg, op[1:0]}] = d;
        OP_SUB_MEM, OP_READ_MAIN, OP_ADD_MEM: expQ.push_back(mem[{rg, ch}]);
        4'hC, 4'hD, 4'hE, 4'hF: expQ.push_back(stat[{rg, op[1:0]}]);
        default: ;
      endcase
    end
    cpu.cyc(1'b1, 1'b0, op, d, xr());
  endtask

  // Each fresh bus drive answers the oldest pending read
  always @(posedge clk_sys) begin
    prevOe <= busOe;
    if (nrst === 1'b1 && busOe === 1'b1 && prevOe !== 1'b1) begin
      // A drive with no read pending is reported through the same check
      if (expQ.size() == 0) check({3'h0, busOe}, 4'h0);
      else check(busOut, expQ.pop_front());
    end
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    failures++;
    $display("BAD %0t: timeout", $time);
    give_verdict();
  end

  initial begin
    logic [3:0] a;
    nrst = 1'b0;
    chipOptionPin = 1'b1;
    failures = 0;
    checks_done = 0;
    clear_model();
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    check(outputPortLines, 4'h0);
    check({3'h0, busOe}, 4'h0);
    $display("test reset done");
    for (int i = 0; i < 2 * MAIN_DEPTH; i++) begin
      src(2'h1, i[5:4], i[3:0]);
      io(i < MAIN_DEPTH ? OP_WRITE_MAIN : OP_READ_MAIN, xr());
    end
    $display("test main sweep done");
    a = xr();
    src(2'h1, a[1:0], xr());
    for (int k = 4; k < 16; k++) io(4'(k > 7 ? k + 4 : k), xr());
    io(OP_WRITE_MAIN, xr());
    io(OP_ADD_MEM, 4'h0);
    io(OP_SUB_MEM, 4'h0);
    $display("test status and arithmetic done");
    for (int k = 0; k < 3; k++) begin
      io(OP_WRITE_PORT, xr());
      check(outputPortLines, port);
      io(OP_WRITE_ROMP, xr());
      io(OP_WRITE_PROG, xr());
      io(OP_READ_ROMP, xr());
      check(outputPortLines, port);
    end
    $display("test port done");
    src(2'h2, 2'h0, 4'h0);
    io(OP_WRITE_MAIN, ~mem[0]);
    io(OP_READ_MAIN, 4'h0);
    io(OP_WRITE_PORT, ~port);
    check(outputPortLines, port);
    chipOptionPin <= 1'b0;
    @(posedge clk_sys);
    src(2'h0, 2'h0, 4'h0);
    io(OP_READ_MAIN, 4'h0);
    // Processor moved to another bank: this line stays low, no answer
    cpu.cyc(1'b0, 1'b0, OP_READ_MAIN, 4'h0, 4'h0);
    // Fourth chip number on the same bank line deselects this part
    src(2'h3, 2'h0, 4'h0);
    io(OP_READ_MAIN, 4'h0);
    $display("test select done");
    nrst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    clear_model();
    src(2'h0, 2'h0, 4'h0);
    io(OP_READ_MAIN, 4'h0);
    io(4'hC, 4'h0);
    check(outputPortLines, 4'h0);
    repeat (4) @(posedge clk_sys);
    check(4'(expQ.size()), 4'h0);
    $display("test second reset done");
    give_verdict();
  end
endmodule  // tb_nbr_ram_port
